// ---- core/sar_pkg.sv ----
// Constants and types for the serial port of the eight-channel converter.
package sar_pkg;
    localparam int RES_W = 12;
    localparam int CTRL_W = 8;
    localparam logic [4:0] FALL_FIRST = 5'h01;
    localparam logic [4:0] FALL_HOLD = 5'h04;
    localparam logic [4:0] FALL_LAST = 5'h10;
    localparam logic [4:0] FALL_TOP = 5'h10;
    localparam logic [3:0] RISE_CTRL_LAST = 4'h7;
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;

    // Layout of the channel select register.
    typedef struct packed {
        logic [1:0] ignored_hi;
        logic [2:0] chan_sel;
        logic [2:0] ignored_lo;
    } sar_ctrl_t;

    typedef enum logic [1:0] {
        PH_OFF = 2'b00,
        PH_TRACK = 2'b01,
        PH_HOLD = 2'b10
    } sar_phase_t;

    // Status seen by the analog side.
    typedef struct packed {
        logic power;
        logic track;
        logic hold;
    } sar_status_t;
endpackage

// ---- core/sar_serial_port.sv ----
// Serial framing, control capture and result shifting of the converter.
`timescale 1ns/1ns
module sar_serial_port (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    // Serial pins from the master
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic DIN_I,
    // Serial data output pin
    output logic DOUT_O,
    output logic DOUT_OE_O,
    // Converter core side
    input wire logic [sar_pkg::RES_W-1:0] RESULT_I,
    output logic [2:0] CHAN_SEL_O,
    output logic SAMPLE_O,
    output sar_pkg::sar_status_t STATUS_O
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic cs_d;
    logic sclk_d;

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            din_sync <= 2'h0;
            cs_d <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], CS_N_I};
            sclk_sync <= {sclk_sync[0], SCLK_I};
            din_sync <= {din_sync[0], DIN_I};
            cs_d <= cs_sync[1];
            sclk_d <= sclk_sync[1];
        end
    end

    // ****************************************
    // Edge events
    // ****************************************
    // Only the second stage and its delayed copy feed the edge logic.
    logic frame;
    logic cs_fall;
    logic fall_tick;
    logic rise_tick;

    assign frame = !cs_sync[1];
    assign cs_fall = cs_d && !cs_sync[1];
    // A low clock at select fall counts as the first falling edge.
    assign fall_tick = frame && (cs_fall ? !sclk_sync[1] : (sclk_d && !sclk_sync[1]));
    assign rise_tick = frame && !cs_fall && !sclk_d && sclk_sync[1];

    // ****************************************
    // Conversion counters
    // ****************************************
    logic [4:0] fall_cnt;
    logic [4:0] next_fall_cnt;
    logic [3:0] rise_cnt;

    always_comb begin
        next_fall_cnt = fall_cnt;
        if (!frame) begin
            next_fall_cnt = 5'h00;
        end else if (cs_fall) begin
            next_fall_cnt = fall_tick ? sar_pkg::FALL_FIRST : 5'h00;
        end else if (fall_tick) begin
            // Wrap after the sixteenth fall gives back-to-back conversions.
            if (fall_cnt == sar_pkg::FALL_TOP || fall_cnt == 5'h00) begin
                next_fall_cnt = sar_pkg::FALL_FIRST;
            end else begin
                next_fall_cnt = fall_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fall_cnt <= 5'h00;
        end else begin
            fall_cnt <= next_fall_cnt;
        end
    end

    // Rising edges wrap every sixteen; the master keeps whole multiples.
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rise_cnt <= 4'h0;
        end else if (!frame || cs_fall) begin
            rise_cnt <= 4'h0;
        end else if (rise_tick) begin
            rise_cnt <= rise_cnt + 4'h1;
        end
    end

    // ****************************************
    // Control byte capture
    // ****************************************
    logic [sar_pkg::CTRL_W-1:0] ctrl_shift;
    sar_pkg::sar_ctrl_t next_ctrl;
    logic [2:0] pending_chan;

    assign next_ctrl = {ctrl_shift[sar_pkg::CTRL_W-2:0], din_sync[1]};

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_shift <= 8'h00;
            pending_chan <= sar_pkg::CHAN_RESET;
        end else if (rise_tick && rise_cnt <= sar_pkg::RISE_CTRL_LAST) begin
            ctrl_shift <= next_ctrl;
            if (rise_cnt == sar_pkg::RISE_CTRL_LAST) begin
                // Only the channel field is kept; the other bits have no effect.
                pending_chan <= next_ctrl.chan_sel;
            end
        end
    end

    // The new code takes effect at the start of the following conversion.
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CHAN_SEL_O <= sar_pkg::CHAN_RESET;
        end else if (fall_tick && next_fall_cnt == sar_pkg::FALL_FIRST) begin
            CHAN_SEL_O <= pending_chan;
        end
    end

    // ****************************************
    // Track, hold and power
    // ****************************************
    sar_pkg::sar_phase_t phase;
    sar_pkg::sar_phase_t next_phase;

    always_comb begin
        case (next_fall_cnt)
            5'h00: next_phase = sar_pkg::PH_OFF;
            5'h01, 5'h02, 5'h03: next_phase = sar_pkg::PH_TRACK;
            default: next_phase = sar_pkg::PH_HOLD;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            phase <= sar_pkg::PH_OFF;
            STATUS_O <= '0;
        end else begin
            phase <= next_phase;
            STATUS_O.track <= (next_phase == sar_pkg::PH_TRACK);
            STATUS_O.hold <= (next_phase == sar_pkg::PH_HOLD);
            // Down while deselected and between fall 16 and the next fall 1.
            STATUS_O.power <= frame && (next_fall_cnt != sar_pkg::FALL_LAST);
        end
    end

    // ****************************************
    // Result latch and serial output
    // ****************************************
    // The core hands over a straight binary code; it is sampled at hold entry.
    logic [sar_pkg::RES_W-1:0] result;
    logic [4:0] bit_idx;

    assign bit_idx = sar_pkg::FALL_TOP - next_fall_cnt;

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            result <= sar_pkg::RESULT_RESET;
            SAMPLE_O <= 1'b0;
        end else begin
            SAMPLE_O <= fall_tick && next_fall_cnt == sar_pkg::FALL_HOLD;
            if (fall_tick && next_fall_cnt == sar_pkg::FALL_HOLD) begin
                result <= RESULT_I;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DOUT_O <= 1'b0;
            DOUT_OE_O <= 1'b0;
        end else begin
            DOUT_OE_O <= frame;
            if (!frame) begin
                DOUT_O <= 1'b0;
            end else if (fall_tick) begin
                if (next_fall_cnt <= sar_pkg::FALL_HOLD) begin
                    DOUT_O <= 1'b0;
                end else begin
                    DOUT_O <= result[bit_idx[3:0]];
                end
            end
        end
    end
endmodule

// ---- test/sar_master.sv ----
// Serial master model driving select, clock and data in.
`timescale 1ns/1ns
module sar_master (
    // Sampled pins
    input wire logic clk_i,
    input wire logic dout_i,
    input wire logic track_i,
    // Driven pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        cs_n_o = 1'h1;
        sclk_o = 1'h0;
        din_o = 1'h0;
    end
    // Mode 0 selects with clock low, 1 with it high, 2 drops both at once.
    task automatic open_frame(input int mode);
        sclk_o <= (mode != 0);
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'h0;
        if (mode == 2) sclk_o <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask
    // Sixteen whole clock periods, so a frame always holds a multiple of 16 rises.
    task automatic convert(input logic [7:0] ctl, output logic [15:0] got,
                           output logic [15:0] trk);
        for (int k = 0; k < 16; k++) begin
            sclk_o <= 1'h0;
            din_o <= (k < 8) ? ctl[7-k] : ~din_o;
            repeat (8) @(posedge clk_i);
            got = {got[14:0], dout_i};
            trk = {trk[14:0], track_i};
            sclk_o <= 1'h1;
            repeat (8) @(posedge clk_i);
        end
    endtask
    // Data in is scrambled once released, so a stale bit is never reused.
    task automatic close_frame();
        cs_n_o <= 1'h1;
        din_o <= ~din_o;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- test/sar_properties.sv ----
// Checker watching the converter serial port pins.
`timescale 1ns/1ns
module sar_props (
    // Watched pins
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic CS_N_I,
    input wire logic DOUT_O,
    input wire logic DOUT_OE_O,
    input wire logic [2:0] CHAN_SEL_O,
    input wire logic SAMPLE_O,
    input wire sar_pkg::sar_status_t STATUS_O
);
    // ***
    // Pin relations.
    // ***
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    a_idle_off: assert property (CS_N_I [*6] |-> !DOUT_OE_O && STATUS_O == 3'h0)
        else $error("busy while deselected");
    a_frame_on: assert property (!CS_N_I [*6] |-> DOUT_OE_O)
        else $error("not driving in frame");
    a_dout_quiet: assert property (!DOUT_OE_O |-> !DOUT_O)
        else $error("data while disabled");
    a_track_zero: assert property (STATUS_O.track |-> !DOUT_O)
        else $error("data during track");
    a_state_excl: assert property (!(STATUS_O.track && STATUS_O.hold))
        else $error("track and hold");
    a_sample_hold: assert property (SAMPLE_O |=> !SAMPLE_O && STATUS_O.hold)
        else $error("sample without hold");
    a_idle_calm: assert property (CS_N_I [*6] |-> !SAMPLE_O)
        else $error("sample while deselected");
    a_chan_hold: assert property (STATUS_O.hold |-> $stable(CHAN_SEL_O))
        else $error("channel moved in hold");
    c_sample: cover property (SAMPLE_O);
    c_pdown: cover property (DOUT_OE_O && !STATUS_O.power);
    c_end: cover property ($fell(DOUT_OE_O));
endmodule
bind sar_serial_port sar_props u_props (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .CS_N_I(CS_N_I),
    .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O), .CHAN_SEL_O(CHAN_SEL_O),
    .SAMPLE_O(SAMPLE_O), .STATUS_O(STATUS_O));

// ---- test/tb_top.sv ----
// Self-checking bench for the converter serial port.
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic cs_n, sclk, din, dout, dout_oe, sample;
    logic [2:0] chan, prev;
    sar_pkg::sar_status_t status;
    logic [11:0] result;
    logic [15:0] got, trk;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_samp = 0;
    // ***
    // Harness.
    // ***
    // Analog stand-in: each code names the channel it came from.
    assign result = {chan, 9'h0B6};
    always #5 mclk = ~mclk;
    sar_master mst (.clk_i(mclk), .dout_i(dout), .track_i(status.track),
        .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
    sar_serial_port uut (.MCLK_I(mclk), .RSTN_I(rstn), .CS_N_I(cs_n), .SCLK_I(sclk),
        .DIN_I(din), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .RESULT_I(result),
        .CHAN_SEL_O(chan), .SAMPLE_O(sample), .STATUS_O(status));
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        n_tests++;
        if (a !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, a, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic t_stream();
        int s0;
        s0 = n_samp;
        mst.open_frame(0);
        mst.convert(8'h18, got, trk);
        chk(got, {4'h0, 3'h0, 9'h0B6});
        chk(trk, 16'hE000);
        chk({14'h0, status.power, dout_oe}, 16'h0001);
        mst.convert(8'hC7, got, trk);
        chk(got, {4'h0, 3'h3, 9'h0B6});
        chk(trk, 16'hE000);
        mst.close_frame();
        chk(16'(n_samp - s0), 16'h0002);
        $display("stream test done");
    endtask
    task automatic t_chan();
        prev = 3'h0;
        for (int c = 0; c < 8; c++) begin
            mst.open_frame(c % 3);
            mst.convert({{2{c[0]}}, 3'(c), {3{c[0]}}}, got, trk);
            chk(got, {4'h0, prev, 9'h0B6});
            mst.close_frame();
            chk({12'h0, status, dout_oe}, 16'h0000);
            prev = 3'(c);
        end
        $display("channel test done");
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'h1;
        repeat (4) @(posedge mclk);
        t_stream();
        t_chan();
        results();
    end
    // A hang ends the run as a failure.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (sample === 1'b1) begin
            n_samp <= n_samp + 1;
        end
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end
endmodule
